//--- pkg/sirc_pkg.sv
// Constants, field layouts and state codes shared by the shared-interrupt
// configuration device end, the configuring host end and their interface.
// Assumes a single clock and one asynchronous active-low reset for both ends.
package sirc_pkg;

  // ****************************************************
  // Sizes
  // ****************************************************
  localparam int SIRC_NUM_SPI = 8;
  localparam int SIRC_IDX_W   = 3;
  localparam int SIRC_ID_W    = 8;
  localparam int SIRC_DOM_W   = 2;
  localparam int SIRC_VM_W    = 4;
  localparam int SIRC_REG_W   = 3;
  localparam int SIRC_HADDR_W = 5;

  // ****************************************************
  // Device register indices
  // ****************************************************
  localparam logic [SIRC_REG_W-1:0] SIRC_REG_SELECT   = 3'h0;
  localparam logic [SIRC_REG_W-1:0] SIRC_REG_STATUS   = 3'h1;
  localparam logic [SIRC_REG_W-1:0] SIRC_REG_TRIGGER  = 3'h2;
  localparam logic [SIRC_REG_W-1:0] SIRC_REG_DOMAIN   = 3'h3;
  localparam logic [SIRC_REG_W-1:0] SIRC_REG_VM       = 3'h4;
  localparam logic [SIRC_REG_W-1:0] SIRC_REG_RESAMPLE = 3'h5;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int SIRC_STAT_IDLE_BIT = 0;
  localparam int SIRC_STAT_V_BIT    = 1;
  localparam int SIRC_TM_BIT        = 0;
  localparam int SIRC_VM_ON_BIT     = 8;

  // ****************************************************
  // Values and reset values
  // ****************************************************
  localparam logic                  SIRC_TM_EDGE     = 1'b0;
  localparam logic                  SIRC_TM_LEVEL    = 1'b1;
  // Highest domain doubles as the most privileged security state's domain
  localparam logic [SIRC_DOM_W-1:0] SIRC_DOM_HIGHEST = 2'h3;
  localparam logic [7:0]            SIRC_ERR_CODE    = 8'h2b;
  localparam logic [SIRC_NUM_SPI-1:0] SIRC_IMPL_MASK     = 8'hff;
  localparam logic [SIRC_NUM_SPI-1:0] SIRC_TM_PROG_MASK  = 8'h7f;
  localparam logic [SIRC_NUM_SPI-1:0] SIRC_TM_FIXED_VAL  = 8'h80;
  localparam logic [SIRC_NUM_SPI-1:0] SIRC_DOM_FIXED_MASK = 8'h40;
  localparam logic                  SIRC_ROUTE_TARGETED = 1'b0;
  localparam logic                  SIRC_ONE_OF_MANY_OK = 1'b0;

  // ****************************************************
  // Host register offsets and operations; event kinds and state codes
  // ****************************************************
  localparam logic [SIRC_HADDR_W-1:0] SIRC_HREG_CMD    = 5'h00;
  localparam logic [SIRC_HADDR_W-1:0] SIRC_HREG_INTERRUPT_IDENTIFIER  = 5'h04;
  localparam logic [SIRC_HADDR_W-1:0] SIRC_HREG_VALUE  = 5'h08;
  localparam logic [SIRC_HADDR_W-1:0] SIRC_HREG_STATUS = 5'h0c;
  localparam logic [SIRC_HADDR_W-1:0] SIRC_HREG_RESULT = 5'h10;
  localparam logic [SIRC_HADDR_W-1:0] SIRC_HREG_DOM    = 5'h14;

  typedef enum logic [1:0] {
    SIRC_OP_VM       = 2'b00,
    SIRC_OP_DOMAIN   = 2'b01,
    SIRC_OP_TRIGGER  = 2'b10,
    SIRC_OP_RESAMPLE = 2'b11
  } sirc_op_type;

  typedef enum logic [1:0] {
    SIRC_EVT_NONE      = 2'b00,
    SIRC_EVT_SET_LEVEL = 2'b01,
    SIRC_EVT_SET_EDGE  = 2'b10,
    SIRC_EVT_CLEAR     = 2'b11
  } sirc_evt_type;

  typedef enum logic [1:0] {
    SIRC_DS_READY = 2'b00,
    SIRC_DS_WORK  = 2'b01,
    SIRC_DS_RAISE = 2'b10
  } sirc_dev_state_type;

  typedef enum logic [3:0] {
    SIRC_HS_IDLE  = 4'h0,
    SIRC_HS_SELW  = 4'h1,
    SIRC_HS_RD1   = 4'h2,
    SIRC_HS_CHK1  = 4'h3,
    SIRC_HS_ACCW  = 4'h4,
    SIRC_HS_RD2   = 4'h5,
    SIRC_HS_CHK2  = 4'h6,
    SIRC_HS_RBRD  = 4'h7,
    SIRC_HS_RBCHK = 4'h8
  } sirc_host_state_type;

endpackage : sirc_pkg

//--- pkg/sirc_cfg_if.sv
// Register path between the configuring host end and the device end.
// Assumes both ends run on the clock given here; no clocking block.
`timescale 1ns/1ps
interface sirc_cfg_if
  import sirc_pkg::*;
(
  input wire logic clk_sys_i
);
  logic [SIRC_REG_W-1:0] addr;
  logic [31:0]           wdata;
  logic                  wr;
  logic                  rd;
  logic [31:0]           rdata;
  logic [SIRC_DOM_W-1:0] dom;

  modport dev  (input addr, wdata, wr, rd, dom, output rdata);
  modport host (output addr, wdata, wr, rd, dom, input rdata);
endinterface : sirc_cfg_if

//--- core/sirc_dev.sv
// Device end: per-interrupt configuration, completion/valid status,
// resampling of wired request lines into interrupt events.
// Assumes request lines synchronous to clk_sys_i and one access at a time.
//
// Overview of operation
// - Level mode resample: set-level or clear event.
// - Edge mode resample: set-edge, else nothing.
// - Completion flag drops before state update.
// - Completion flag rises after state update.
// - Programmable trigger modes reset to edge.
// - No virtual machine assignment after reset.
// - Reset domain is most privileged state's.
// - Reset: disabled, inactive, idle.
// - Routing mode resets to targeted.
// - Only vm ids left uninitialised.
// - Reset returns all but vm ids together.
// - Software selects, polls, checks valid first.
// - Software polls and checks after vm write.
// - Domain changes only from highest domain.
// - Software polls after domain write.
// - Fixed domain ignores change attempts.
// - Software detects fixed domain by readback.
// - Fix domain only where solely handled.
// - Resample only when managed and reachable.
// - Valid flag shows reachable implemented selection.
// - Completion flag tracks last effectful write.
`timescale 1ns/1ps
module sirc_dev
  import sirc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_b_i,
  // Register path
  sirc_cfg_if.dev                      cfg,
  // Request lines
  input  wire logic [SIRC_NUM_SPI-1:0] irq_i,
  // Events
  output logic                         evt_valid_o,
  output sirc_pkg::sirc_evt_type       evt_kind_o,
  output logic [SIRC_ID_W-1:0]         evt_id_o,
  // Error report
  output logic                         sw_err_o,
  output logic [7:0]                   err_code_o,
  // Interrupt state
  output logic [SIRC_NUM_SPI-1:0]      pend_o,
  output logic [SIRC_NUM_SPI-1:0]      enabled_o,
  output logic [SIRC_NUM_SPI-1:0]      active_o,
  output logic [SIRC_NUM_SPI-1:0]      route_o
);
  import sirc_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  sirc_dev_state_type                   state_r;
  logic                                 idle_r;
  logic                                 valid_r;
  logic [SIRC_ID_W-1:0]                 sel_r;
  logic [SIRC_REG_W-1:0]                op_r;
  logic [31:0]                          data_r;
  logic [SIRC_DOM_W-1:0]                acc_r;
  logic [SIRC_NUM_SPI-1:0]              tm_r;
  logic [SIRC_NUM_SPI-1:0]              vm_on_r;
  logic [SIRC_NUM_SPI-1:0][SIRC_VM_W-1:0]  vm_id_r;
  logic [SIRC_NUM_SPI-1:0][SIRC_DOM_W-1:0] dom_r;
  logic [SIRC_NUM_SPI-1:0]              pend_r;
  logic [SIRC_NUM_SPI-1:0]              enabled_r;
  logic [SIRC_NUM_SPI-1:0]              active_r;
  logic [SIRC_NUM_SPI-1:0]              route_r;
  logic [31:0]                          rdata_r;

  // Managed, implemented and reachable from the accessing domain
  function automatic logic reach(input logic [SIRC_ID_W-1:0]  id,
                                 input logic [SIRC_DOM_W-1:0] acc,
                                 input logic [SIRC_NUM_SPI-1:0][SIRC_DOM_W-1:0] doms);
    logic [SIRC_IDX_W-1:0] ix;
    ix = id[SIRC_IDX_W-1:0];
    reach = (id < SIRC_ID_W'(SIRC_NUM_SPI)) && SIRC_IMPL_MASK[ix] &&
            ((acc == doms[ix]) || (acc == SIRC_DOM_HIGHEST));
  endfunction : reach

  // ****************************************************
  // Decode
  // ****************************************************
  wire                  ready     = (state_r == SIRC_DS_READY);
  wire                  wr_sel    = cfg.wr && (cfg.addr == SIRC_REG_SELECT);
  wire                  wr_cfg    = cfg.wr && (cfg.addr == SIRC_REG_TRIGGER);
  wire                  wr_dom    = cfg.wr && (cfg.addr == SIRC_REG_DOMAIN);
  wire                  wr_vm     = cfg.wr && (cfg.addr == SIRC_REG_VM);
  wire                  wr_rs     = cfg.wr && (cfg.addr == SIRC_REG_RESAMPLE);
  wire [SIRC_ID_W-1:0]  rs_id_in  = cfg.wdata[SIRC_ID_W-1:0];
  wire                  rs_ok_in  = reach(rs_id_in, cfg.dom, dom_r);
  wire                  start     = ready && (wr_sel || wr_cfg || wr_dom || wr_vm ||
                                              (wr_rs && rs_ok_in));
  wire                  rs_bad    = ready && wr_rs && !rs_ok_in;
  wire                  work      = (state_r == SIRC_DS_WORK);
  wire [SIRC_IDX_W-1:0] sel_ix    = sel_r[SIRC_IDX_W-1:0];
  wire                  sel_ok    = reach(sel_r, acc_r, dom_r);
  wire [SIRC_IDX_W-1:0] rs_ix     = data_r[SIRC_IDX_W-1:0];
  wire                  do_rs     = work && (op_r == SIRC_REG_RESAMPLE);
  wire                  do_cfg    = work && (op_r == SIRC_REG_TRIGGER) && sel_ok;
  wire                  do_vm     = work && (op_r == SIRC_REG_VM) && sel_ok;
  // Domain moves need a valid selection and a domain write made from the highest domain
  wire                  do_dom    = work && (op_r == SIRC_REG_DOMAIN) && valid_r && sel_ok &&
                                    (acc_r == SIRC_DOM_HIGHEST) &&
                                    !SIRC_DOM_FIXED_MASK[sel_ix];
  wire [SIRC_DOM_W-1:0] new_dom   = data_r[SIRC_DOM_W-1:0];
  wire                  rs_line   = irq_i[rs_ix];
  wire                  rs_level  = (tm_r[rs_ix] == SIRC_TM_LEVEL);
  wire sirc_evt_type    evt_nxt   = !rs_line ? (rs_level ? SIRC_EVT_CLEAR : SIRC_EVT_NONE)
                                             : (rs_level ? SIRC_EVT_SET_LEVEL : SIRC_EVT_SET_EDGE);
  wire                  rd_ok     = valid_r && reach(sel_r, cfg.dom, dom_r);
  wire [31:0]           rd_word   =
    (cfg.addr == SIRC_REG_STATUS)  ? {30'h0, valid_r, idle_r} :
    (cfg.addr == SIRC_REG_SELECT)  ? {24'h0, sel_r} :
    (cfg.addr == SIRC_REG_TRIGGER && rd_ok) ? {31'h0, tm_r[sel_ix]} :
    (cfg.addr == SIRC_REG_DOMAIN && rd_ok)  ? {30'h0, dom_r[sel_ix]} :
    (cfg.addr == SIRC_REG_VM && rd_ok)      ? {23'h0, vm_on_r[sel_ix], 4'h0, vm_id_r[sel_ix]} :
    32'h0;

  // ****************************************************
  // Sequencer: drop flag, update, raise flag
  // ****************************************************
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= SIRC_DS_READY;
      idle_r  <= 1'b1;
      op_r    <= SIRC_REG_SELECT;
      data_r  <= 32'h0;
      acc_r   <= SIRC_DOM_HIGHEST;
    end
    else
    begin
      case (state_r)
        SIRC_DS_READY:
        begin
          if (start)
          begin
            idle_r  <= 1'b0;
            op_r    <= cfg.addr;
            data_r  <= cfg.wdata;
            acc_r   <= cfg.dom;
            state_r <= SIRC_DS_WORK;
          end
        end
        SIRC_DS_WORK:  state_r <= SIRC_DS_RAISE;
        SIRC_DS_RAISE:
        begin
          idle_r  <= 1'b1;
          state_r <= SIRC_DS_READY;
        end
        default:       state_r <= SIRC_DS_READY;
      endcase
    end
  end

  // ****************************************************
  // Selection and valid flag
  // ****************************************************
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sel_r   <= '0;
      valid_r <= 1'b0;
    end
    else if (work && op_r == SIRC_REG_SELECT)
    begin
      sel_r   <= data_r[SIRC_ID_W-1:0];
      valid_r <= reach(data_r[SIRC_ID_W-1:0], acc_r, dom_r);
    end
    else if (work && (op_r == SIRC_REG_TRIGGER || op_r == SIRC_REG_VM))
    begin
      valid_r <= sel_ok;
    end
  end

  // ****************************************************
  // Per-interrupt configuration
  // ****************************************************
  // Vm ids are left unreset: only meaningful once an assignment is made
  always_ff @(posedge clk_sys_i)
  begin
    if (do_vm)
    begin
      vm_id_r[sel_ix] <= data_r[SIRC_VM_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tm_r      <= SIRC_TM_FIXED_VAL & ~SIRC_TM_PROG_MASK;
      vm_on_r   <= '0;
      dom_r     <= {SIRC_NUM_SPI{SIRC_DOM_HIGHEST}};
    end
    else
    begin
      if (do_cfg && SIRC_TM_PROG_MASK[sel_ix])
      begin
        tm_r[sel_ix] <= data_r[SIRC_TM_BIT];
      end
      if (do_vm)
      begin
        vm_on_r[sel_ix] <= data_r[SIRC_VM_ON_BIT];
      end
      if (do_dom && new_dom != dom_r[sel_ix])
      begin
        // A moved interrupt carries no vm assignment into its new domain
        dom_r[sel_ix]   <= new_dom;
        vm_on_r[sel_ix] <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Interrupt state and events
  // ****************************************************
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pend_r      <= '0;
      enabled_r   <= '0;
      active_r    <= '0;
      route_r     <= {SIRC_NUM_SPI{SIRC_ROUTE_TARGETED}};
      evt_valid_o <= 1'b0;
      evt_kind_o  <= SIRC_EVT_NONE;
      evt_id_o    <= '0;
      sw_err_o    <= 1'b0;
      err_code_o  <= 8'h00;
    end
    else
    begin
      evt_valid_o <= do_rs && (evt_nxt != SIRC_EVT_NONE);
      evt_kind_o  <= do_rs ? evt_nxt : SIRC_EVT_NONE;
      evt_id_o    <= do_rs ? data_r[SIRC_ID_W-1:0] : evt_id_o;
      if (do_rs && evt_nxt != SIRC_EVT_NONE)
      begin
        pend_r[rs_ix] <= (evt_nxt != SIRC_EVT_CLEAR);
      end
      sw_err_o    <= rs_bad;
      err_code_o  <= rs_bad ? SIRC_ERR_CODE : err_code_o;
      enabled_r   <= enabled_r;
      active_r    <= active_r;
      route_r     <= SIRC_ONE_OF_MANY_OK ? route_r : {SIRC_NUM_SPI{SIRC_ROUTE_TARGETED}};
    end
  end

  // ****************************************************
  // Read port
  // ****************************************************
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_r <= 32'h0;
    end
    else
    begin
      rdata_r <= cfg.rd ? rd_word : 32'h0;
    end
  end

  assign cfg.rdata = rdata_r;
  assign pend_o    = pend_r;
  assign enabled_o = enabled_r;
  assign active_o  = active_r;
  assign route_o   = route_r;

endmodule : sirc_dev

//--- core/sirc_host.sv
// Host end: runs the select, poll, access and readback sequences on behalf
// of software that orders them through a small register port.
// Assumes the device end answers reads one cycle after the read strobe.
`timescale 1ns/1ps
module sirc_host
  import sirc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_b_i,
  // Software port
  input  wire logic [SIRC_HADDR_W-1:0] addr_i,
  input  wire logic [31:0]             wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic [31:0]                  rdata_o,
  // Register path
  sirc_cfg_if.host                     cfg
);
  import sirc_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  sirc_host_state_type   state_r;
  sirc_op_type           op_r;
  logic [SIRC_ID_W-1:0]  interrupt_identifier_r;
  logic [31:0]           value_r;
  logic [31:0]           result_r;
  logic [SIRC_DOM_W-1:0] dom_r;
  logic                  ok_r;
  logic                  fail_r;
  logic                  mism_r;
  logic [SIRC_REG_W-1:0] baddr_r;
  logic [31:0]           bwdata_r;
  logic                  bwr_r;
  logic                  brd_r;

  wire busy     = (state_r != SIRC_HS_IDLE);
  wire start    = wr_i && (addr_i == SIRC_HREG_CMD) && !busy;
  wire cmd_rs   = (sirc_op_type'(wdata_i[1:0]) == SIRC_OP_RESAMPLE);
  wire st_idle  = cfg.rdata[SIRC_STAT_IDLE_BIT];
  wire st_v     = cfg.rdata[SIRC_STAT_V_BIT];
  wire [SIRC_REG_W-1:0] target =
    (op_r == SIRC_OP_VM)      ? SIRC_REG_VM :
    (op_r == SIRC_OP_DOMAIN)  ? SIRC_REG_DOMAIN :
    (op_r == SIRC_OP_TRIGGER) ? SIRC_REG_TRIGGER : SIRC_REG_RESAMPLE;
  // Domain writes refresh no valid flag, and a resample has no selection
  wire need_v2  = (op_r == SIRC_OP_VM) || (op_r == SIRC_OP_TRIGGER);
  wire [31:0] rd_word =
    (addr_i == SIRC_HREG_INTERRUPT_IDENTIFIER)  ? {24'h0, interrupt_identifier_r} :
    (addr_i == SIRC_HREG_VALUE)  ? value_r :
    (addr_i == SIRC_HREG_STATUS) ? {28'h0, mism_r, fail_r, ok_r, busy} :
    (addr_i == SIRC_HREG_RESULT) ? result_r :
    (addr_i == SIRC_HREG_DOM)    ? {30'h0, dom_r} :
    (addr_i == SIRC_HREG_CMD)    ? {30'h0, op_r} : 32'h0;

  // ****************************************************
  // Software registers
  // ****************************************************
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      interrupt_identifier_r <= '0;
      value_r <= 32'h0;
      dom_r   <= SIRC_DOM_HIGHEST;
      rdata_o <= 32'h0;
    end
    else
    begin
      // Arguments are frozen while a sequence runs
      if (wr_i && !busy && addr_i == SIRC_HREG_INTERRUPT_IDENTIFIER) interrupt_identifier_r <= wdata_i[SIRC_ID_W-1:0];
      if (wr_i && !busy && addr_i == SIRC_HREG_VALUE) value_r <= wdata_i;
      if (wr_i && !busy && addr_i == SIRC_HREG_DOM)   dom_r   <= wdata_i[SIRC_DOM_W-1:0];
      rdata_o <= rd_i ? rd_word : 32'h0;
    end
  end

  // ****************************************************
  // Sequencer; the state names what the bus carries
  // ****************************************************
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r  <= SIRC_HS_IDLE;
      op_r     <= SIRC_OP_VM;
      result_r <= 32'h0;
      ok_r     <= 1'b0;
      fail_r   <= 1'b0;
      mism_r   <= 1'b0;
      baddr_r  <= SIRC_REG_SELECT;
      bwdata_r <= 32'h0;
      bwr_r    <= 1'b0;
      brd_r    <= 1'b0;
    end
    else
    begin
      bwr_r <= 1'b0;
      brd_r <= 1'b0;
      case (state_r)
        SIRC_HS_IDLE:
        begin
          if (start)
          begin
            op_r     <= sirc_op_type'(wdata_i[1:0]);
            ok_r     <= 1'b0;
            fail_r   <= 1'b0;
            mism_r   <= 1'b0;
            bwr_r    <= 1'b1;
            baddr_r  <= cmd_rs ? SIRC_REG_RESAMPLE : SIRC_REG_SELECT;
            bwdata_r <= {24'h0, interrupt_identifier_r};
            state_r  <= cmd_rs ? SIRC_HS_ACCW : SIRC_HS_SELW;
          end
        end
        SIRC_HS_SELW, SIRC_HS_ACCW:
        begin
          brd_r   <= 1'b1;
          baddr_r <= SIRC_REG_STATUS;
          state_r <= (state_r == SIRC_HS_SELW) ? SIRC_HS_RD1 : SIRC_HS_RD2;
        end
        SIRC_HS_RD1:   state_r <= SIRC_HS_CHK1;
        SIRC_HS_RD2:   state_r <= SIRC_HS_CHK2;
        SIRC_HS_RBRD:  state_r <= SIRC_HS_RBCHK;
        SIRC_HS_CHK1:
        begin
          if (!st_idle)
          begin
            brd_r   <= 1'b1;
            state_r <= SIRC_HS_RD1;
          end
          else if (!st_v)
          begin
            fail_r  <= 1'b1;
            state_r <= SIRC_HS_IDLE;
          end
          else
          begin
            bwr_r    <= 1'b1;
            baddr_r  <= target;
            bwdata_r <= value_r;
            state_r  <= SIRC_HS_ACCW;
          end
        end
        SIRC_HS_CHK2:
        begin
          if (!st_idle)
          begin
            brd_r   <= 1'b1;
            state_r <= SIRC_HS_RD2;
          end
          else if (need_v2 && !st_v)
          begin
            fail_r  <= 1'b1;
            state_r <= SIRC_HS_IDLE;
          end
          else if (op_r == SIRC_OP_RESAMPLE)
          begin
            ok_r    <= 1'b1;
            state_r <= SIRC_HS_IDLE;
          end
          else
          begin
            brd_r   <= 1'b1;
            baddr_r <= target;
            state_r <= SIRC_HS_RBRD;
          end
        end
        SIRC_HS_RBCHK:
        begin
          result_r <= cfg.rdata;
          ok_r     <= 1'b1;
          mism_r   <= (cfg.rdata != value_r);
          state_r  <= SIRC_HS_IDLE;
        end
        default:       state_r <= SIRC_HS_IDLE;
      endcase
    end
  end

  assign cfg.addr  = baddr_r;
  assign cfg.wdata = bwdata_r;
  assign cfg.wr    = bwr_r;
  assign cfg.rd    = brd_r;
  assign cfg.dom   = dom_r;

endmodule : sirc_host

//--- sim/sirc_checker.sv
// Checker on the register path between host end and device end.
// Assumes one clock domain; watches interface signals only.
`timescale 1ns/1ps
module sirc_checker
  import sirc_pkg::*;
(
  input wire logic                  clk_sys_i,
  input wire logic                  rst_b_i,
  input wire logic [SIRC_REG_W-1:0] addr,
  input wire logic [31:0]           wdata,
  input wire logic                  wr,
  input wire logic                  rd,
  input wire logic [31:0]           rdata,
  input wire logic [SIRC_DOM_W-1:0] dom
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic st_r;
  logic go_r;
  wire  rd_st = rd && addr == SIRC_REG_STATUS;
  wire  rs_w  = wr && addr == SIRC_REG_RESAMPLE;
  wire  cfg_w = wr && addr < SIRC_REG_RESAMPLE && addr != SIRC_REG_STATUS;
  wire  acc   = (wr || rd) && (addr == SIRC_REG_VM || addr == SIRC_REG_DOMAIN);
  // Set by a status read of {v,idle} = 11, lost on any write
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      {st_r, go_r} <= 2'b00;
    else
      {st_r, go_r} <= {rd_st, !wr && (st_r ? rdata[1:0] == 2'b11 : go_r)};
  end
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_idle_drops: assert property (
    (cfg_w || rs_w && wdata < 32'h8 && dom == SIRC_DOM_HIGHEST)
    ##1 rd_st |=> !rdata[SIRC_STAT_IDLE_BIT])
    else $error("idle not low after write");
  a_idle_back: assert property ((cfg_w || rs_w) ##1 !wr [*2] ##1 rd_st
    |=> rdata[SIRC_STAT_IDLE_BIT])
    else $error("idle not back after write");
  a_sel_valid: assert property (
    wr && addr == SIRC_REG_SELECT && dom == SIRC_DOM_HIGHEST ##1 !wr [*2] ##1 rd_st
    |=> rdata[SIRC_STAT_V_BIT] == ($past(wdata, 4) < 32'h8))
    else $error("valid flag wrong");
  a_access_gated: assert property (acc |-> go_r)
    else $error("access without idle and valid");
  a_dom_top: assert property (wr && addr == SIRC_REG_DOMAIN |-> dom == SIRC_DOM_HIGHEST)
    else $error("domain write from lower domain");
  a_one_strobe: assert property (!(wr && rd))
    else $error("read and write together");
  a_rs_refused: assert property (rs_w && wdata >= 32'h8 ##1 rd_st
    |=> rdata[SIRC_STAT_IDLE_BIT])
    else $error("refused resample went busy");
  cover property (rs_w && wdata < 32'h8);
  cover property (cfg_w ##1 !wr [*2] ##1 rd_st);
  cover property (wr && addr == SIRC_REG_DOMAIN);
endmodule : sirc_checker

//--- sim/testbench.sv
// Bench joining host end and device end over the register path.
// Assumes each command completes within the status poll bound.
`timescale 1ns/1ps
module testbench;
  import sirc_pkg::*;
  logic         clk_sys_i, rst_b_i, wr_i, rd_i, evt_valid_o, sw_err_o;
  logic [4:0]   addr_i;
  logic [31:0]  wdata_i, rdata_o, rdv;
  logic [7:0]   irq_i, evt_id_o, err_code_o, pend_o, enabled_o, active_o, route_o, ev_id;
  logic [1:0]   ev_k;
  sirc_evt_type evt_kind_o;
  int           n_errors = 0, n_checks = 0, n_evt, n_sw;
  sirc_cfg_if cfg (.clk_sys_i);
  sirc_host u_sirc_host (.clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cfg);
  sirc_dev u_sirc_dev (.clk_sys_i, .rst_b_i, .cfg, .irq_i, .evt_valid_o, .evt_kind_o,
    .evt_id_o, .sw_err_o, .err_code_o, .pend_o, .enabled_o, .active_o, .route_o);
  sirc_checker u_sirc_checker (.clk_sys_i, .rst_b_i, .addr(cfg.addr), .wdata(cfg.wdata),
    .wr(cfg.wr), .rd(cfg.rd), .rdata(cfg.rdata), .dom(cfg.dom));
  // Falling edge keeps event sampling clear of the flops' own edge
  always @(negedge clk_sys_i)
  begin
    n_sw += int'(sw_err_o === 1'b1);
    if (evt_valid_o === 1'b1)
      {n_evt, ev_k, ev_id} = {n_evt + 1, evt_kind_o, evt_id_o};
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic sw(input logic [4:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_sys_i);
    {addr_i, wdata_i, wr_i, rd_i} <= {a, d, w, !w};
    @(posedge clk_sys_i);
    {wr_i, rd_i} <= 2'b00;
    // Answer stood since the last edge; leaving on an edge keeps later drives on edges
    @(posedge clk_sys_i);
    rdv = rdata_o;
  endtask : sw
  task automatic cmd(input logic [31:0] op, id, v, d, st);
    sw(SIRC_HREG_INTERRUPT_IDENTIFIER, id, 1'b1);
    sw(SIRC_HREG_VALUE, v, 1'b1);
    sw(SIRC_HREG_DOM, d, 1'b1);
    sw(SIRC_HREG_CMD, op, 1'b1);
    rdv = '1;
    repeat (40)
      if (rdv[0] !== 1'b0)
        sw(SIRC_HREG_STATUS, 0, 1'b0);
    chk("status", rdv[3:0], {st[2:0], 1'b0});
  endtask : cmd
  task automatic res(input logic [31:0] id, d, k);
    {n_evt, ev_k, ev_id} = {32'h0, 2'h0, 8'hff};
    cmd(SIRC_OP_RESAMPLE, id, 0, d, 3'b001);
    if (k == 0)
      id = 32'hff;
    chk("event", {n_evt[7:0], ev_k, ev_id}, {7'h0, k != 0, k[1:0], id[7:0]});
  endtask : res
  task automatic rst;
    rst_b_i <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    chk("reset", {pend_o, enabled_o, active_o, route_o}, 0);
  endtask : rst
  task automatic t_trig;
    irq_i <= 8'h06;
    res(1, 3, SIRC_EVT_SET_EDGE);
    res(0, 3, SIRC_EVT_NONE);
    chk("pending", pend_o, 8'h02);
    cmd(SIRC_OP_TRIGGER, 2, 1, 3, 3'b001);
    res(2, 3, SIRC_EVT_SET_LEVEL);
    irq_i <= 8'h00;
    res(2, 3, SIRC_EVT_CLEAR);
  endtask : t_trig
  task automatic t_cfg;
    cmd(SIRC_OP_DOMAIN, 6, 1, 3, 3'b101);
    sw(SIRC_HREG_RESULT, 0, 1'b0);
    chk("fixed domain", rdv, 32'h3);
    cmd(SIRC_OP_DOMAIN, 3, 1, 3, 3'b001);
    cmd(SIRC_OP_VM, 9, 32'h105, 3, 3'b010);
    cmd(SIRC_OP_VM, 0, 32'h105, 3, 3'b001);
    sw(SIRC_HREG_RESULT, 0, 1'b0);
    chk("vm readback", rdv, 32'h105);
  endtask : t_cfg
  task automatic t_refuse;
    n_sw = 0;
    irq_i <= 8'h08;
    res(9, 3, SIRC_EVT_NONE);
    res(3, 2, SIRC_EVT_NONE);
    chk("refusals", {n_sw[7:0], err_code_o}, {8'h2, SIRC_ERR_CODE});
    res(3, 1, SIRC_EVT_SET_EDGE);
  endtask : t_refuse
  task automatic t_rst;
    rst();
    irq_i <= 8'h0c;
    res(2, 3, SIRC_EVT_SET_EDGE);
    res(3, 1, SIRC_EVT_NONE);
  endtask : t_rst
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    {rst_b_i, wr_i, rd_i, addr_i, wdata_i, irq_i, n_sw} = '0;
    rst();
    t_trig();
    t_cfg();
    t_refuse();
    t_rst();
    summarize();
  end
  initial
  begin
    #200us;
    n_errors++;
    summarize();
  end
endmodule : testbench
